// file: logic/fdr_consts.svh
// fdr_consts.svh: offsets, field positions, reset values and timing for the drive/rate block
//
// Contract
// (RULE_01) normal external decode: binary select, one motor line
// (RULE_02) swapped decode: invert low select for drives 0/1
// (RULE_03) normal mode: tape register bits 7:2 undriven
// (RULE_04) tape select bits 1:0 writable and readable
// (RULE_05) mode 2: rate pins become inputs, bits 7:6
// (RULE_06) media code high follows pin, inverted by config bit 3
// (RULE_07) media code low follows pin, inverted by config bit 2
// (RULE_08) drive type bits from config pair per drive
// (RULE_09) boot drive bits from boot config bits 1:0
// (RULE_10) write-only rate register shares status address
// (RULE_11) operating rate from latest rate or control write
// (RULE_12) host should program rate through control register
// (RULE_13) software reset leaves rate register unchanged
// (RULE_14) hardware reset loads rate register with 02h
// (RULE_15) rate code decode, fm at top rate illegal
// (RULE_16) precomp field: 111 off, steps, 000 default
// (RULE_17) power down until soft reset or controller access
// (RULE_18) rate register reset bit resets, then self clears
// (RULE_19) mode and swap come from outside configuration inputs
`ifndef FDR_CONSTS_SVH
`define FDR_CONSTS_SVH

// ************************************************************
// register offsets on the host i/o bus
// ************************************************************
`define FDR_ADDR_W 10
`define FDR_OFS_DOR 10'h3f2
`define FDR_OFS_TAPE 10'h3f3
`define FDR_OFS_RATE 10'h3f4
`define FDR_OFS_DATA 10'h3f5
`define FDR_OFS_CCR 10'h3f7

// ************************************************************
// field positions
// ************************************************************
`define FDR_DOR_RESET_N_BIT 2
`define FDR_DOR_MOTOR_LSB 4
`define FDR_RATE_SWRST_BIT 7
`define FDR_RATE_PWRDN_BIT 6
`define FDR_RATE_PRE_MSB 4
`define FDR_RATE_PRE_LSB 2
`define FDR_BOOT_MEDIA_HI_INV_BIT 3
`define FDR_BOOT_MEDIA_LO_INV_BIT 2

// ************************************************************
// reset values
// ************************************************************
`define FDR_DOR_RESET 8'h00
`define FDR_TAPE_RESET 2'h0
`define FDR_RATE_RESET 8'h02
`define FDR_DRIVEN_MASK_NORMAL 8'h03

// ************************************************************
// precompensation, in 41.67 ns steps
// ************************************************************
`define FDR_PRE_OFF 3'h7
`define FDR_PRE_DEFAULT 3'h0
`define FDR_PRE_DEF_1M 3'h1
`define FDR_PRE_DEF_OTHER 3'h3

`endif

// file: logic/fdr_pkg.sv
// fdr_pkg.sv: types shared by the drive/rate block
`default_nettype none
package fdr_pkg;
    // data rate select codes
    typedef enum logic [1:0] {
        FDR_RATE_500K = 2'b00,
        FDR_RATE_300K = 2'b01,
        FDR_RATE_250K = 2'b10,
        FDR_RATE_1M = 2'b11
    } fdr_rate_t;

    typedef logic [1:0] fdr_drive_t;
endpackage : fdr_pkg
`default_nettype wire

// file: logic/fdr_drv_if.sv
// fdr_drv_if.sv: carrier between the register bank and the drive decoder
`timescale 1ns/1ps
`default_nettype none
interface fdr_drv_if;
    logic [7:0] digital_output_reg;
    logic swap;
    logic sel_hi_n;
    logic sel_lo_n;
    logic mot_a_n;
    logic mot_b_n;

    modport bank (output digital_output_reg, output swap, input sel_hi_n, input sel_lo_n,
                  input mot_a_n, input mot_b_n);
    modport dec (input digital_output_reg, input swap, output sel_hi_n, output sel_lo_n,
                 output mot_a_n, output mot_b_n);
endinterface : fdr_drv_if
`default_nettype wire

// file: logic/fdr_drive_decode.sv
// fdr_drive_decode.sv: external 2-to-4 drive decode, normal and swapped
`timescale 1ns/1ps
`default_nettype none
module fdr_drive_decode
    import fdr_pkg::*;
(
    // decode carrier
    fdr_drv_if.dec drv
);
    `include "fdr_consts.svh"

    fdr_drive_t dn;
    logic [3:0] mot_en;

    // select lines carry the drive number; swap only touches drives 0 and 1
    always_comb begin
        dn = drv.digital_output_reg[1:0];
        mot_en = drv.digital_output_reg[`FDR_DOR_MOTOR_LSB +: 4];
        drv.sel_hi_n = dn[1]; // RULE_01
        drv.sel_lo_n = dn[0] ^ (drv.swap & ~dn[1]); // RULE_02
        drv.mot_a_n = ~mot_en[dn]; // RULE_01
        drv.mot_b_n = 1'b1; // second motor line unused by external decode
    end
endmodule : fdr_drive_decode
`default_nettype wire

// file: logic/fdr_regs.sv
// fdr_regs.sv: drive output, tape/media and data rate registers of the floppy block
`timescale 1ns/1ps
`default_nettype none
module fdr_regs
    import fdr_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // host register port
    input wire logic [9:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic [7:0] bus_rdata_oe_n,
    // configuration held outside the block
    input wire logic enh_mode2,
    input wire logic swap_drives,
    input wire logic [7:0] drive_type_config,
    input wire logic [7:0] boot_media_config,
    input wire logic fm_sel,
    // drive interface
    output logic drive_sel_hi_n,
    output logic drive_sel_lo_n,
    output logic motor_on_a_n,
    output logic motor_on_b_n,
    // data rate pins, two-way
    input wire logic rate_pin_low_in,
    input wire logic rate_pin_high_in,
    output logic rate_pin_low_out,
    output logic rate_pin_high_out,
    output logic rate_pins_oe_n,
    // controller side
    output logic ctrl_reset,
    output logic power_down,
    output logic [1:0] op_rate,
    output logic rate_illegal,
    output logic [2:0] precomp_steps,
    output logic [2:0] precomp_start_sel
);
    `include "fdr_consts.svh"

    // ************************************************************
    // address decode
    // ************************************************************
    logic wr_dor, wr_tape, wr_rate, wr_ccr, rd_dor, rd_tape, ctrl_access;

    always_comb begin
        wr_dor = bus_wr && (bus_addr == `FDR_OFS_DOR);
        wr_tape = bus_wr && (bus_addr == `FDR_OFS_TAPE);
        wr_rate = bus_wr && (bus_addr == `FDR_OFS_RATE); // RULE_10
        wr_ccr = bus_wr && (bus_addr == `FDR_OFS_CCR);
        rd_dor = bus_rd && (bus_addr == `FDR_OFS_DOR);
        rd_tape = bus_rd && (bus_addr == `FDR_OFS_TAPE);
        // status read and any data access wake the controller
        ctrl_access = (bus_rd && (bus_addr == `FDR_OFS_RATE)) ||
                      ((bus_rd || bus_wr) && (bus_addr == `FDR_OFS_DATA));
    end

    // ************************************************************
    // rate pin synchroniser
    // ************************************************************
    // no reset here: the sampled pin levels survive both resets
    logic [1:0] pin_meta, pin_sync;

    always_ff @(posedge clk) begin
        if (clk_en) begin
            pin_meta <= {rate_pin_high_in, rate_pin_low_in};
            pin_sync <= pin_meta; // RULE_05
        end
    end

    // ************************************************************
    // software visible state
    // ************************************************************
    logic [7:0] digital_output_reg, next_dor;
    logic [1:0] tape, next_tape;
    logic [7:0] rate_reg, next_rate_reg;
    logic [1:0] cur_rate, next_cur_rate;
    logic swrst_pulse, next_swrst_pulse;
    logic pwr_dn, next_pwr_dn;
    logic soft_rst;

    // register writes and the self clearing reset strobe
    always_comb begin
        next_dor = digital_output_reg;
        next_tape = tape;
        next_rate_reg = rate_reg;
        next_cur_rate = cur_rate;
        next_swrst_pulse = 1'b0;
        next_pwr_dn = pwr_dn;
        if (wr_dor) begin
            next_dor = bus_wdata;
        end
        if (wr_tape) begin
            next_tape = bus_wdata[1:0]; // RULE_04
        end
        if (wr_rate) begin
            // the reset bit is stored as zero; it acts only as a strobe
            next_rate_reg = bus_wdata;
            next_rate_reg[`FDR_RATE_SWRST_BIT] = 1'b0; // RULE_18
            next_rate_reg[5] = 1'b0; // RULE_10
            next_swrst_pulse = bus_wdata[`FDR_RATE_SWRST_BIT]; // RULE_18
            next_cur_rate = bus_wdata[1:0]; // RULE_11
        end else if (wr_ccr) begin
            next_cur_rate = bus_wdata[1:0]; // RULE_11 RULE_12
        end
        // entering low power needs a write; leaving it wins over entering in the same cycle
        if (wr_rate && bus_wdata[`FDR_RATE_PWRDN_BIT]) begin
            next_pwr_dn = 1'b1; // RULE_17
        end
        if (soft_rst || ctrl_access) begin
            next_pwr_dn = 1'b0; // RULE_17
        end
    end

    // soft reset never touches the registers above, only power down
    always_comb begin
        soft_rst = ~digital_output_reg[`FDR_DOR_RESET_N_BIT] | swrst_pulse; // RULE_13 RULE_18
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            digital_output_reg <= `FDR_DOR_RESET;
            tape <= `FDR_TAPE_RESET;
            rate_reg <= `FDR_RATE_RESET; // RULE_14
            cur_rate <= 2'b10; // RULE_14
            swrst_pulse <= 1'b0;
            pwr_dn <= 1'b0;
        end else if (clk_en) begin
            digital_output_reg <= next_dor;
            tape <= next_tape;
            rate_reg <= next_rate_reg;
            cur_rate <= next_cur_rate;
            swrst_pulse <= next_swrst_pulse;
            pwr_dn <= next_pwr_dn;
        end
    end

    // ************************************************************
    // drive decode
    // ************************************************************
    fdr_drv_if drv ();

    always_comb begin
        drv.digital_output_reg = digital_output_reg;
        drv.swap = swap_drives; // RULE_19
    end

    fdr_drive_decode u_dec (
        .drv (drv.dec)
    );

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] tape_view;
    logic [7:0] next_rdata, next_oe_n;
    fdr_drive_t last_drive;

    // assembles the tape/media/boot view of the tape register
    always_comb begin
        last_drive = digital_output_reg[1:0];
        tape_view = 8'h00;
        tape_view[1:0] = tape; // RULE_04
        if (enh_mode2) begin
            tape_view[7] = pin_sync[1] ^
                           boot_media_config[`FDR_BOOT_MEDIA_HI_INV_BIT]; // RULE_06
            tape_view[6] = pin_sync[0] ^
                           boot_media_config[`FDR_BOOT_MEDIA_LO_INV_BIT]; // RULE_07
            tape_view[5:4] = drive_type_config[{last_drive, 1'b0} +: 2]; // RULE_08
            tape_view[3:2] = boot_media_config[1:0]; // RULE_09
        end
    end

    // read data for the cycle after the strobe; unmapped reads stay undriven
    always_comb begin
        next_rdata = 8'h00;
        next_oe_n = 8'hff;
        if (rd_dor) begin
            next_rdata = digital_output_reg;
            next_oe_n = 8'h00;
        end else if (rd_tape) begin
            next_rdata = tape_view;
            next_oe_n = enh_mode2 ? 8'h00 : ~`FDR_DRIVEN_MASK_NORMAL; // RULE_03
        end
    end

    // ************************************************************
    // rate and precomp decode
    // ************************************************************
    logic [2:0] pre_field, next_pre_steps;
    logic next_illegal;
    logic [1:0] next_pin_out;
    logic next_pins_oe_n;

    always_comb begin
        pre_field = rate_reg[`FDR_RATE_PRE_MSB:`FDR_RATE_PRE_LSB];
        next_illegal = fm_sel && (fdr_rate_t'(cur_rate) == FDR_RATE_1M); // RULE_15
        if (pre_field == `FDR_PRE_OFF) begin
            next_pre_steps = 3'h0; // RULE_16
        end else if (pre_field == `FDR_PRE_DEFAULT) begin
            // default delay depends on the rate in force
            next_pre_steps = (fdr_rate_t'(cur_rate) == FDR_RATE_1M) ?
                             `FDR_PRE_DEF_1M : `FDR_PRE_DEF_OTHER; // RULE_16
        end else begin
            next_pre_steps = pre_field; // RULE_16
        end
        // outside mode 2 the pins report the rate code to the drives
        next_pin_out = cur_rate;
        next_pins_oe_n = enh_mode2; // RULE_05
    end

    // ************************************************************
    // output registers
    // ************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= 8'h00;
            bus_rdata_oe_n <= 8'hff;
            drive_sel_hi_n <= 1'b0;
            drive_sel_lo_n <= 1'b0;
            motor_on_a_n <= 1'b1;
            motor_on_b_n <= 1'b1;
            rate_pin_low_out <= 1'b0;
            rate_pin_high_out <= 1'b1;
            rate_pins_oe_n <= 1'b1;
            ctrl_reset <= 1'b1;
            power_down <= 1'b0;
            op_rate <= 2'b10;
            rate_illegal <= 1'b0;
            precomp_steps <= `FDR_PRE_DEF_OTHER;
            precomp_start_sel <= 3'h0;
        end else if (clk_en) begin
            bus_rdata <= next_rdata;
            bus_rdata_oe_n <= next_oe_n;
            drive_sel_hi_n <= drv.sel_hi_n; // RULE_01
            drive_sel_lo_n <= drv.sel_lo_n; // RULE_02
            motor_on_a_n <= drv.mot_a_n; // RULE_01
            motor_on_b_n <= drv.mot_b_n; // RULE_01
            rate_pin_low_out <= next_pin_out[0];
            rate_pin_high_out <= next_pin_out[1];
            rate_pins_oe_n <= next_pins_oe_n; // RULE_05
            ctrl_reset <= soft_rst; // RULE_18
            power_down <= pwr_dn; // RULE_17
            op_rate <= cur_rate; // RULE_11 RULE_15
            rate_illegal <= next_illegal; // RULE_15
            precomp_steps <= next_pre_steps; // RULE_16
            precomp_start_sel <= pre_field;
        end
    end
endmodule : fdr_regs
`default_nettype wire

// file: verification/fdr_regs_chk.sv
// fdr_regs_chk.sv: port assertions for the drive/rate block
`timescale 1ns/1ps
`default_nettype none
module fdr_regs_chk
    import fdr_pkg::*;
(
    // clock, reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // host port
    input wire logic [9:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic [7:0] bus_rdata_oe_n,
    // config and outputs
    input wire logic enh_mode2,
    input wire logic swap_drives,
    input wire logic drive_sel_hi_n,
    input wire logic drive_sel_lo_n,
    input wire logic motor_on_a_n,
    input wire logic [1:0] op_rate,
    input wire logic [2:0] precomp_steps,
    input wire logic [2:0] precomp_start_sel
);
    // ***
    // request decodes
    // ***
    logic dor_wr, rate_wr, tape_rd, map_rd, wr_lo, wr_mot;
    // swap is held steady by the bench, so write-time value is safe
    // a strobe counts only when the enable lets the block take it
    assign dor_wr = clk_en && bus_wr && bus_addr == 10'h3f2;
    assign rate_wr = clk_en && bus_wr && (bus_addr == 10'h3f4 || bus_addr == 10'h3f7);
    assign tape_rd = clk_en && bus_rd && bus_addr == 10'h3f3;
    assign map_rd = tape_rd || (clk_en && bus_rd && bus_addr == 10'h3f2);
    assign wr_lo = bus_wdata[0] ^ (swap_drives & ~bus_wdata[1]);
    assign wr_mot = bus_wdata[{1'b1, bus_wdata[1:0]}];
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // write effects land two edges after the strobe
    a_bus_undriven: assert property (!$past(map_rd) |-> bus_rdata_oe_n == 8'hff)
        else $error("undriven read drove bits");
    a_tape_normal: assert property ($past(tape_rd && !enh_mode2) |-> bus_rdata_oe_n == 8'hfc)
        else $error("normal tape read enables wrong");
    a_tape_mode2: assert property ($past(tape_rd && enh_mode2) |-> bus_rdata_oe_n == 8'h00)
        else $error("mode 2 tape read enables wrong");
    a_sel_high: assert property ($past(dor_wr, 2) |-> drive_sel_hi_n == $past(bus_wdata[1], 2))
        else $error("high select wrong");
    a_sel_low: assert property ($past(dor_wr, 2) |-> drive_sel_lo_n == $past(wr_lo, 2))
        else $error("low select wrong");
    a_motor_line: assert property ($past(dor_wr, 2) |-> motor_on_a_n == !$past(wr_mot, 2))
        else $error("motor line wrong");
    a_rate_load: assert property ($past(rate_wr, 2) |-> op_rate == $past(bus_wdata[1:0], 2))
        else $error("operating rate not loaded");
    a_precomp_map: assert property (precomp_steps == (precomp_start_sel == 3'h7 ? 3'h0 :
        precomp_start_sel != 3'h0 ? precomp_start_sel : op_rate == 2'b11 ? 3'h1 : 3'h3))
        else $error("precomp steps wrong");
    c_tape_m2: cover property ($past(tape_rd && enh_mode2));
    c_swapped: cover property ($past(dor_wr, 2) && swap_drives);
    c_pre_def: cover property (precomp_start_sel == 3'h0 && op_rate == 2'b11);
endmodule : fdr_regs_chk
`default_nettype wire

// file: verification/fdr_drive_model.sv
// fdr_drive_model.sv: four drives behind the external select decoder
`timescale 1ns/1ps
`default_nettype none
module fdr_drive_model
    import fdr_pkg::*;
(
    // decoder side
    input wire logic sel_hi_n,
    input wire logic sel_lo_n,
    input wire logic mot_n,
    // media code of each drive, two bits apiece
    input wire logic [7:0] media_tbl,
    output logic [1:0] media
);
    // motor off: drive lets go and the pull-ups win
    assign media = mot_n ? 2'b11 : media_tbl[{sel_hi_n, sel_lo_n, 1'b0} +: 2];
endmodule : fdr_drive_model
`default_nettype wire

// file: verification/fdr_regs_tb.sv
// fdr_regs_tb.sv: self-checking bench for the drive/rate block
`timescale 1ns/1ps
`default_nettype none
module fdr_regs_tb
    import fdr_pkg::*;
;
    // ***
    // bench signals
    // ***
    logic clk, sys_rst, clk_en, bus_wr, bus_rd, enh_mode2, swap_drives, fm_sel;
    logic sel_hi, sel_lo, mot_a, mot_b, p_lo, p_hi, p_oe_n, crst, pdn, bad;
    logic [9:0] bus_addr;
    logic [7:0] bus_wdata, dtc, bmc, rdata, oe_n, media_tbl, rd_val, rd_oe, v, w;
    logic [1:0] op_rate, media;
    logic [2:0] steps, pre_sel;
    int n_fail, samples_checked, i;
    // block drives the rate pins outside mode 2, the drives inside it
    wire logic pin_lo = p_oe_n ? media[0] : p_lo;
    wire logic pin_hi = p_oe_n ? media[1] : p_hi;
    fdr_regs fdr_regs_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(rdata),
        .bus_rdata_oe_n(oe_n), .enh_mode2(enh_mode2), .swap_drives(swap_drives),
        .drive_type_config(dtc), .boot_media_config(bmc), .fm_sel(fm_sel),
        .drive_sel_hi_n(sel_hi), .drive_sel_lo_n(sel_lo), .motor_on_a_n(mot_a),
        .motor_on_b_n(mot_b), .rate_pin_low_in(pin_lo), .rate_pin_high_in(pin_hi),
        .rate_pin_low_out(p_lo), .rate_pin_high_out(p_hi), .rate_pins_oe_n(p_oe_n),
        .ctrl_reset(crst), .power_down(pdn), .op_rate(op_rate), .rate_illegal(bad),
        .precomp_steps(steps), .precomp_start_sel(pre_sel));
    fdr_drive_model fdr_drive_model_i (.sel_hi_n(sel_hi), .sel_lo_n(sel_lo), .mot_n(mot_a),
        .media_tbl(media_tbl), .media(media));
    // expected {sel_hi, sel_lo, mot_b, mot_a}
    function automatic logic [7:0] dec_exp(input logic [7:0] d);
        return {4'h0, d[1], d[0] ^ (swap_drives & ~d[1]), 1'b1, ~d[{1'b1, d[1:0]}]};
    endfunction : dec_exp
    // expected mode 2 read of the tape/media register
    function automatic logic [7:0] tape_exp(input logic [7:0] d, input logic [1:0] t);
        logic [7:0] e;
        logic [1:0] pn;
        e = dec_exp(d);
        pn = d[{1'b1, d[1:0]}] ? media_tbl[{e[3:2], 1'b0} +: 2] : 2'b11;
        return {pn ^ bmc[3:2], dtc[{d[1:0], 1'b0} +: 2], bmc[1:0], t};
    endfunction : tape_exp
    function automatic logic [7:0] steps_exp(input logic [2:0] f, input logic [1:0] r);
        return f == 3'h7 ? 8'h0 : f != 3'h0 ? 8'(f) : r == 2'b11 ? 8'h1 : 8'h3;
    endfunction : steps_exp
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : wr
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [9:0] a);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        rd_val = rdata;
        rd_oe = oe_n;
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // watchdog well past the scripted run
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        {sys_rst, clk_en, bus_wr, bus_rd, enh_mode2, swap_drives, fm_sel} = 7'b1100000;
        bus_addr = 10'h0;
        {bus_wdata, dtc, bmc, media_tbl} = 32'h0;
        n_fail = 0;
        samples_checked = 0;
        void'($urandom(32'h7fa4063f));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        settle(1);
        chk("rate_rst", 8'h02, {3'b0, pre_sel, op_rate});
        // every drive number, both modes, both orders
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            enh_mode2 <= i[0];
            swap_drives <= i[1];
            dtc <= 8'($urandom);
            bmc <= 8'($urandom);
            media_tbl <= 8'($urandom);
            w = 8'($urandom);
            v = {4'($urandom), 2'b01, 2'(i >> 2)};
            wr(10'h3f3, w);
            wr(10'h3f2, v);
            settle(6);
            chk("decode", dec_exp(v), {4'h0, sel_hi, sel_lo, mot_b, mot_a});
            chk("pin_oe", {7'h0, enh_mode2}, {7'h0, p_oe_n});
            rd(10'h3f3);
            if (enh_mode2) chk("tape", tape_exp(v, w[1:0]), rd_val);
            else chk("tape", {6'h0, w[1:0]}, rd_val & 8'h03);
            chk("tape_oe", enh_mode2 ? 8'h00 : 8'hfc, rd_oe);
        end
        // every rate and precomp code, latest write wins
        for (i = 0; i < 32; i++) begin
            @(posedge clk);
            fm_sel <= i[1];
            v = {3'b000, 3'(i), 2'(i >> 3)};
            w = 8'($urandom);
            wr(10'h3f4, v);
            if (i[2]) wr(10'h3f7, w);
            else w = v;
            settle(3);
            chk("rate", {6'h0, w[1:0]}, {6'h0, op_rate});
            chk("pin_out", {6'h0, w[1:0]}, {6'h0, p_hi, p_lo});
            chk("pre_sel", {5'h0, v[4:2]}, {5'h0, pre_sel});
            chk("steps", steps_exp(v[4:2], w[1:0]), {5'h0, steps});
            chk("illegal", {7'h0, fm_sel && w[1:0] == 2'b11}, {7'h0, bad});
        end
        wr(10'h3f4, 8'h4b);
        settle(2);
        chk("pdn_set", 8'h01, {7'h0, pdn});
        rd(10'h3f4);
        chk("rate_oe", 8'hff, rd_oe);
        settle(2);
        chk("pdn_wake", 8'h00, {7'h0, pdn});
        wr(10'h3f4, 8'h4b);
        wr(10'h3f5, 8'h00);
        settle(2);
        chk("pdn_data", 8'h00, {7'h0, pdn});
        wr(10'h3f4, 8'h8b);
        i = 0;
        repeat (4) begin
            settle(1);
            i += int'(crst);
        end
        chk("swrst", 8'h01, {7'h0, i > 0 && crst === 1'b0});
        chk("swrst_keep", 8'h0b, {3'b0, pre_sel, op_rate});
        // a write while the enable is low must not be taken
        @(posedge clk);
        clk_en <= 1'b0;
        wr(10'h3f4, 8'h00);
        settle(2);
        chk("frozen", 8'h0b, {3'b0, pre_sel, op_rate});
        @(posedge clk);
        clk_en <= 1'b1;
        rd(10'h3f0);
        chk("unmapped", 8'hff, rd_oe);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        settle(1);
        chk("hw_rst", 8'h02, {3'b0, pre_sel, op_rate});
        wrap_up();
    end
endmodule : fdr_regs_tb
bind fdr_regs fdr_regs_chk fdr_regs_chk_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .bus_rdata_oe_n(bus_rdata_oe_n), .enh_mode2(enh_mode2), .swap_drives(swap_drives),
    .drive_sel_hi_n(drive_sel_hi_n), .drive_sel_lo_n(drive_sel_lo_n),
    .motor_on_a_n(motor_on_a_n), .op_rate(op_rate), .precomp_steps(precomp_steps),
    .precomp_start_sel(precomp_start_sel));
`default_nettype wire
